/* File: rda_pkg.sv */
package rda_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_A0_SEC = 8'h0C;
	localparam logic [7:0] OFS_A0_MIN = 8'h0D;
	localparam logic [7:0] OFS_A0_HOUR = 8'h0E;
	localparam logic [7:0] OFS_A0_WKDAY = 8'h0F;
	localparam logic [7:0] OFS_A0_DATE = 8'h10;
	localparam logic [7:0] OFS_A0_MONTH = 8'h11;
	localparam logic [7:0] OFS_A1_HSEC = 8'h12;
	localparam logic [7:0] OFS_A1_SEC = 8'h13;
	localparam logic [7:0] OFS_A1_MIN = 8'h14;
	localparam logic [7:0] OFS_A1_HOUR = 8'h15;
	localparam logic [7:0] OFS_A1_WKDAY = 8'h16;
	localparam logic [7:0] OFS_A1_DATE = 8'h17;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam logic [7:0] SEC_WMASK = 8'h7F;
	localparam logic [7:0] MIN_WMASK = 8'h7F;
	localparam logic [7:0] HOUR_WMASK = 8'h3F;
	localparam logic [7:0] DATE_WMASK = 8'h3F;
	localparam logic [7:0] MONTH_WMASK = 8'h1F;
	localparam int HOUR_FMT_BIT = 6;
	localparam int WK_PIN_BIT = 7;
	localparam int WK_MASK_LSB = 4;
	localparam int WK_FLAG_BIT = 3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] MATCH_RESET = 8'h00;
	localparam logic [2:0] WKDAY_RESET = 3'h1;

	// ------------------------------------------------------------
	// Match select codes
	// ------------------------------------------------------------
	localparam logic [2:0] SEL_SEC = 3'h0;
	localparam logic [2:0] SEL_MIN = 3'h1;
	localparam logic [2:0] SEL_HOUR = 3'h2;
	localparam logic [2:0] SEL_WKDAY = 3'h3;
	localparam logic [2:0] SEL_DATE = 3'h4;
	localparam logic [2:0] SEL_HSEC = 3'h5;
	localparam logic [2:0] SEL_RSVD = 3'h6;
	localparam logic [2:0] SEL_ALL = 3'h7;

	// Reserved select for a given alarm unit
	function automatic logic sel_reserved(input logic [2:0] sel, input logic has_hsec);
		sel_reserved = (sel == SEL_RSVD) || ((sel == SEL_HSEC) && !has_hsec);
	endfunction

endpackage

/* File: rda_alarm_match.sv */
`timescale 1ns/100ps
module rda_alarm_match #(
	parameter bit HAS_HSEC = 1'b0
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Configuration
	input wire logic enable,
	input wire logic [2:0] sel,
	// Match values
	input wire logic [7:0] m_hsec,
	input wire logic [7:0] m_sec,
	input wire logic [7:0] m_min,
	input wire logic [5:0] m_hour,
	input wire logic [2:0] m_wkday,
	input wire logic [7:0] m_date,
	input wire logic [7:0] m_month,
	// Timekeeping values
	input wire logic tick,
	input wire logic [7:0] t_hsec,
	input wire logic [7:0] t_sec,
	input wire logic [7:0] t_min,
	input wire logic [5:0] t_hour,
	input wire logic [2:0] t_wkday,
	input wire logic [7:0] t_date,
	input wire logic [7:0] t_month,
	// Result
	output logic set_pulse
);

	logic hit;
	logic prev_reg;
	logic prev_next;

	// ------------------------------------------------------------
	// Masked comparison
	// ------------------------------------------------------------
	always_comb begin
		hit = 1'b0;
		if (enable && !rda_pkg::sel_reserved(sel, HAS_HSEC)) begin
			case (sel)
				rda_pkg::SEL_SEC: hit = (m_sec == t_sec);
				rda_pkg::SEL_MIN: hit = (m_min == t_min);
				rda_pkg::SEL_HOUR: hit = (m_hour == t_hour);
				rda_pkg::SEL_WKDAY: hit = (m_wkday == t_wkday);
				rda_pkg::SEL_DATE: hit = (m_date == t_date);
				rda_pkg::SEL_HSEC: hit = (m_hsec == t_hsec);
				rda_pkg::SEL_ALL: begin
					// Month only takes part on the unit without hundredths
					hit = (m_sec == t_sec) && (m_min == t_min) && (m_hour == t_hour)
						&& (m_wkday == t_wkday) && (m_date == t_date)
						&& (HAS_HSEC || (m_month == t_month));
				end
				default: hit = 1'b0;
			endcase
		end
	end

	// Sampled only on the counter update so every granularity sees the same instant
	always_comb begin
		prev_next = prev_reg;
		if (tick) begin
			prev_next = hit;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= prev_next;
		end
	end

	assign set_pulse = tick && hit && !prev_reg;

endmodule

/* File: rda_alarm.sv */
`timescale 1ns/100ps
// Function
// - Two alarm units with separate controls, match values, flags and enables.
// - One-shot or repeating alarms; per-second repeat only on the second unit.
// - Each alarm has its own flag, set by hardware on its selected match.
// - Hardware never clears a flag; the host clears it by a write.
// - Each alarm routes to the interrupt pin or watchdog pin by its own bit.
// - Alarm outputs keep working on backup supply, for either routing.
// - Match and time values are packed BCD, tens high, ones low.
// - First alarm codes 000-100 compare seconds, minutes, hours, weekday, date alone.
// - First alarm codes 101, 110 reserved; 111 compares all fields including month.
// - Second alarm codes 000-100 as first alarm; 101 compares hundredths.
// - Second alarm 110 reserved; 111 compares all fields except month and hundredths.
// - Only the second alarm has a hundredths match register, two BCD digits.
// - Seconds match reads bit 7 zero, tens 0-5, ones 0-9.
// - Minutes match reads bit 7 zero, tens 0-5, ones 0-9.
// - Hours match: bit 7 zero, bit 6 read-only format, bits 5-0 hour digits.
// - Hour format bit mirrors the timekeeping hours format selection.
// - Weekday register holds routing bit, mask code, flag and weekday match.
module rda_alarm (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	output logic [7:0] reg_rdata,
	// Alarm enables
	input wire logic alarm0_enable,
	input wire logic alarm1_enable,
	// Timekeeping counters
	input wire logic tk_tick,
	input wire logic [7:0] tk_hundredths,
	input wire logic [7:0] tk_seconds,
	input wire logic [7:0] tk_minutes,
	input wire logic [7:0] tk_hours,
	input wire logic [2:0] tk_weekday,
	input wire logic [7:0] tk_date,
	input wire logic [7:0] tk_month,
	// Alarm outputs
	output logic irq_alarm,
	output logic watchdog_out_pin
);

	// ------------------------------------------------------------
	// Per-alarm storage
	// ------------------------------------------------------------
	logic [7:0] sec_reg [2];
	logic [7:0] sec_next [2];
	logic [7:0] min_reg [2];
	logic [7:0] min_next [2];
	logic [5:0] hour_reg [2];
	logic [5:0] hour_next [2];
	logic [7:0] date_reg [2];
	logic [7:0] date_next [2];
	logic pin_sel_reg [2];
	logic pin_sel_next [2];
	logic [2:0] match_sel_reg [2];
	logic [2:0] match_sel_next [2];
	logic [1:0] alarm_flag_reg;
	logic [1:0] alarm_flag_next;
	logic [2:0] wkday_reg [2];
	logic [2:0] wkday_next [2];
	logic [7:0] month_reg;
	logic [7:0] month_next;
	logic [7:0] hsec_reg;
	logic [7:0] hsec_next;
	logic [7:0] rdata_next;
	logic irq_next;
	logic wdo_next;
	logic [1:0] set_pulse;
	logic [1:0] enable;
	logic [1:0] wr_wkday;

	assign enable = {alarm1_enable, alarm0_enable};
	assign wr_wkday[0] = reg_write && (reg_addr == rda_pkg::OFS_A0_WKDAY);
	assign wr_wkday[1] = reg_write && (reg_addr == rda_pkg::OFS_A1_WKDAY);

	// ------------------------------------------------------------
	// Match units
	// ------------------------------------------------------------
	// One match unit per alarm, each with private controls
	for (genvar i = 0; i < 2; i++) begin : g_unit
		rda_alarm_match #(
			.HAS_HSEC(i == 1)
		) u_match (
			.mclk(mclk),
			.rst(rst),
			.enable(enable[i]),
			.sel(match_sel_reg[i]),
			.m_hsec(hsec_reg),
			.m_sec(sec_reg[i]),
			.m_min(min_reg[i]),
			.m_hour(hour_reg[i]),
			.m_wkday(wkday_reg[i]),
			.m_date(date_reg[i]),
			.m_month(month_reg),
			.tick(tk_tick),
			.t_hsec(tk_hundredths),
			.t_sec(tk_seconds),
			.t_min(tk_minutes),
			.t_hour(tk_hours[5:0]),
			.t_wkday(tk_weekday),
			.t_date(tk_date),
			.t_month(tk_month),
			.set_pulse(set_pulse[i])
		);
	end

	// ------------------------------------------------------------
	// Register writes and flags
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			sec_next[i] = sec_reg[i];
			min_next[i] = min_reg[i];
			hour_next[i] = hour_reg[i];
			date_next[i] = date_reg[i];
			pin_sel_next[i] = pin_sel_reg[i];
			match_sel_next[i] = match_sel_reg[i];
			wkday_next[i] = wkday_reg[i];
			alarm_flag_next[i] = alarm_flag_reg[i];
			if (wr_wkday[i]) begin
				pin_sel_next[i] = reg_wdata[rda_pkg::WK_PIN_BIT];
				match_sel_next[i] = reg_wdata[rda_pkg::WK_MASK_LSB +: 3];
				wkday_next[i] = reg_wdata[2:0];
				// Host can only clear the flag; writing one keeps it
				alarm_flag_next[i] = alarm_flag_reg[i] && reg_wdata[rda_pkg::WK_FLAG_BIT];
			end
			// A match in the clearing cycle wins over the clear
			if (set_pulse[i]) begin
				alarm_flag_next[i] = 1'b1;
			end
		end
		month_next = month_reg;
		hsec_next = hsec_reg;
		if (reg_write) begin
			if (reg_addr == rda_pkg::OFS_A0_SEC) begin
				sec_next[0] = reg_wdata & rda_pkg::SEC_WMASK;
			end else if (reg_addr == rda_pkg::OFS_A1_SEC) begin
				sec_next[1] = reg_wdata & rda_pkg::SEC_WMASK;
			end else if (reg_addr == rda_pkg::OFS_A0_MIN) begin
				min_next[0] = reg_wdata & rda_pkg::MIN_WMASK;
			end else if (reg_addr == rda_pkg::OFS_A1_MIN) begin
				min_next[1] = reg_wdata & rda_pkg::MIN_WMASK;
			end else if (reg_addr == rda_pkg::OFS_A0_HOUR) begin
				hour_next[0] = reg_wdata[5:0];
			end else if (reg_addr == rda_pkg::OFS_A1_HOUR) begin
				hour_next[1] = reg_wdata[5:0];
			end else if (reg_addr == rda_pkg::OFS_A0_DATE) begin
				date_next[0] = reg_wdata & rda_pkg::DATE_WMASK;
			end else if (reg_addr == rda_pkg::OFS_A1_DATE) begin
				date_next[1] = reg_wdata & rda_pkg::DATE_WMASK;
			end else if (reg_addr == rda_pkg::OFS_A0_MONTH) begin
				month_next = reg_wdata & rda_pkg::MONTH_WMASK;
			end else if (reg_addr == rda_pkg::OFS_A1_HSEC) begin
				hsec_next = reg_wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Read decode and pin routing
	// ------------------------------------------------------------
	always_comb begin
		rdata_next = 8'h00;
		if (reg_addr == rda_pkg::OFS_A0_SEC) begin
			rdata_next = sec_reg[0];
		end else if (reg_addr == rda_pkg::OFS_A1_SEC) begin
			rdata_next = sec_reg[1];
		end else if (reg_addr == rda_pkg::OFS_A0_MIN) begin
			rdata_next = min_reg[0];
		end else if (reg_addr == rda_pkg::OFS_A1_MIN) begin
			rdata_next = min_reg[1];
		end else if (reg_addr == rda_pkg::OFS_A0_HOUR) begin
			rdata_next = {1'b0, tk_hours[rda_pkg::HOUR_FMT_BIT], hour_reg[0]};
		end else if (reg_addr == rda_pkg::OFS_A1_HOUR) begin
			rdata_next = {1'b0, tk_hours[rda_pkg::HOUR_FMT_BIT], hour_reg[1]};
		end else if (reg_addr == rda_pkg::OFS_A0_WKDAY) begin
			rdata_next = {pin_sel_reg[0], match_sel_reg[0], alarm_flag_reg[0], wkday_reg[0]};
		end else if (reg_addr == rda_pkg::OFS_A1_WKDAY) begin
			rdata_next = {pin_sel_reg[1], match_sel_reg[1], alarm_flag_reg[1], wkday_reg[1]};
		end else if (reg_addr == rda_pkg::OFS_A0_DATE) begin
			rdata_next = date_reg[0];
		end else if (reg_addr == rda_pkg::OFS_A1_DATE) begin
			rdata_next = date_reg[1];
		end else if (reg_addr == rda_pkg::OFS_A0_MONTH) begin
			rdata_next = month_reg;
		end else if (reg_addr == rda_pkg::OFS_A1_HSEC) begin
			rdata_next = hsec_reg;
		end
		// No supply gating here: the outputs follow the flags on any supply
		irq_next = 1'b0;
		wdo_next = 1'b0;
		for (int i = 0; i < 2; i++) begin
			if (alarm_flag_reg[i] && enable[i]) begin
				if (pin_sel_reg[i]) begin
					wdo_next = 1'b1;
				end else begin
					irq_next = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 2; i++) begin
				sec_reg[i] <= rda_pkg::MATCH_RESET;
				min_reg[i] <= rda_pkg::MATCH_RESET;
				hour_reg[i] <= 6'h00;
				date_reg[i] <= rda_pkg::MATCH_RESET;
				pin_sel_reg[i] <= 1'b0;
				match_sel_reg[i] <= 3'h0;
				wkday_reg[i] <= rda_pkg::WKDAY_RESET;
			end
			alarm_flag_reg <= 2'h0;
			month_reg <= rda_pkg::MATCH_RESET;
			hsec_reg <= rda_pkg::MATCH_RESET;
			reg_rdata <= 8'h00;
			irq_alarm <= 1'b0;
			watchdog_out_pin <= 1'b0;
		end else begin
			sec_reg <= sec_next;
			min_reg <= min_next;
			hour_reg <= hour_next;
			date_reg <= date_next;
			pin_sel_reg <= pin_sel_next;
			match_sel_reg <= match_sel_next;
			wkday_reg <= wkday_next;
			alarm_flag_reg <= alarm_flag_next;
			month_reg <= month_next;
			hsec_reg <= hsec_next;
			reg_rdata <= rdata_next;
			irq_alarm <= irq_next;
			watchdog_out_pin <= wdo_next;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
		alarm_flag_reg[0] && !wr_wkday[0] |=> alarm_flag_reg[0])
		else $error("alarm 0 flag dropped without a host write");

	a_flag_set: assert property (@(posedge mclk) disable iff (rst)
		set_pulse[1] |=> alarm_flag_reg[1])
		else $error("alarm 1 match did not set its flag");

	a_flag_set0: assert property (@(posedge mclk) disable iff (rst)
		set_pulse[0] |=> alarm_flag_reg[0])
		else $error("alarm 0 match did not set its flag");

	a_flag_clear: assert property (@(posedge mclk) disable iff (rst)
		wr_wkday[1] && !reg_wdata[rda_pkg::WK_FLAG_BIT] && !set_pulse[1] |=> !alarm_flag_reg[1])
		else $error("alarm 1 flag not cleared by host write");

	a_set_on_tick: assert property (@(posedge mclk) disable iff (rst)
		(set_pulse != 2'h0) |-> tk_tick)
		else $error("alarm flag set outside a counter update");

	a_reserved_quiet: assert property (@(posedge mclk) disable iff (rst)
		(match_sel_reg[0] == rda_pkg::SEL_RSVD || match_sel_reg[0] == rda_pkg::SEL_HSEC
			|| !alarm0_enable) |-> !set_pulse[0])
		else $error("alarm 0 set while disabled or reserved");

	a_quiet_unit1: assert property (@(posedge mclk) disable iff (rst)
		(match_sel_reg[1] == rda_pkg::SEL_RSVD || !alarm1_enable) |-> !set_pulse[1])
		else $error("alarm 1 set while disabled or reserved");

	a_first_match: assert property (@(posedge mclk) disable iff (rst)
		set_pulse[1] ##1 (tk_tick && $stable(tk_hundredths) && $stable(match_sel_reg[1])
			&& $stable(hsec_reg) && $stable(alarm1_enable)) |-> !set_pulse[1])
		else $error("alarm 1 set twice on a standing match");

	a_route_irq: assert property (@(posedge mclk) disable iff (rst)
		alarm_flag_reg[0] && alarm0_enable && !pin_sel_reg[0] |=> irq_alarm)
		else $error("alarm 0 not routed to interrupt pin");

	a_route_wdo: assert property (@(posedge mclk) disable iff (rst)
		!(alarm_flag_reg[0] && alarm0_enable && pin_sel_reg[0])
			&& !(alarm_flag_reg[1] && alarm1_enable && pin_sel_reg[1]) |=> !watchdog_out_pin)
		else $error("watchdog pin driven with no routed alarm");

	a_irq_quiet: assert property (@(posedge mclk) disable iff (rst)
		!(alarm_flag_reg[0] && alarm0_enable && !pin_sel_reg[0])
			&& !(alarm_flag_reg[1] && alarm1_enable && !pin_sel_reg[1]) |=> !irq_alarm)
		else $error("interrupt pin driven with no routed alarm");

	a_min_bit7: assert property (@(posedge mclk) disable iff (rst)
		reg_addr == rda_pkg::OFS_A0_MIN |=> !reg_rdata[7])
		else $error("minutes match bit 7 read as one");

	a_sec_bit7: assert property (@(posedge mclk) disable iff (rst)
		reg_addr == rda_pkg::OFS_A1_SEC |=> !reg_rdata[7])
		else $error("seconds match bit 7 read as one");

	a_hour_format: assert property (@(posedge mclk) disable iff (rst)
		reg_addr == rda_pkg::OFS_A0_HOUR |=> reg_rdata[6] == $past(tk_hours[6]) && !reg_rdata[7])
		else $error("hours match format bit does not mirror timekeeping");

endmodule

/* File: rda_host_model.sv */
`timescale 1ns/100ps
module rda_host_model (
	// Clock
	input wire logic mclk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	input wire logic [7:0] reg_rdata
);
	// ------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
	end

	// Writes any byte as given; callers also hand in digits outside their BCD ranges
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask

	// Read data is registered, so the address is held over two edges
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		repeat (2) @(posedge mclk);
		#1;
		d = reg_rdata;
	endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_write;
	logic [7:0] reg_rdata;
	logic alarm0_enable = 1'b0;
	logic alarm1_enable = 1'b0;
	logic tk_tick = 1'b0;
	logic [7:0] tk_hundredths = 8'h00;
	logic [7:0] tk_seconds = 8'h00;
	logic [7:0] tk_minutes = 8'h00;
	logic [7:0] tk_hours = 8'h00;
	logic [2:0] tk_weekday = 3'h0;
	logic [7:0] tk_date = 8'h00;
	logic [7:0] tk_month = 8'h00;
	logic irq_alarm;
	logic watchdog_out_pin;
	int fails = 0;
	int n_compared = 0;
	logic [7:0] rv;
	// Fields: hundredths, seconds, minutes, hours, weekday, date, month
	logic [7:0] mv [7] = '{8'h37, 8'h25, 8'h41, 8'h51, 8'h05, 8'h28, 8'h11};
	logic [7:0] dv [7] = '{8'h52, 8'h07, 8'h09, 8'h61, 8'h02, 8'h03, 8'h06};
	logic [7:0] ma [10] = '{8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h17};
	int mf [10] = '{1, 2, 3, 5, 6, 0, 1, 2, 3, 5};
	logic [7:0] ta [5] = '{8'h0C, 8'h0D, 8'h0E, 8'h12, 8'h18};
	logic [7:0] td [5] = '{8'hD9, 8'hD9, 8'hE3, 8'h99, 8'h55};
	logic [7:0] te [5] = '{8'h59, 8'h59, 8'h23, 8'h99, 8'h00};

	always #4 mclk = ~mclk;

	rda_alarm i_rda_alarm (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_rdata(reg_rdata), .alarm0_enable(alarm0_enable),
		.alarm1_enable(alarm1_enable), .tk_tick(tk_tick), .tk_hundredths(tk_hundredths),
		.tk_seconds(tk_seconds), .tk_minutes(tk_minutes), .tk_hours(tk_hours),
		.tk_weekday(tk_weekday), .tk_date(tk_date), .tk_month(tk_month),
		.irq_alarm(irq_alarm), .watchdog_out_pin(watchdog_out_pin));

	rda_host_model i_rda_host_model (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_rdata(reg_rdata));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic give_verdict();
		if (fails == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		i_rda_host_model.rd(a, rv);
		chk(rv, exp);
	endtask

	// Pin p: 0 interrupt request, 1 watchdog pin
	task automatic out_chk(input logic p, input logic e);
		chk({6'h00, watchdog_out_pin, irq_alarm}, {6'h00, p && e, !p && e});
	endtask

	// Bit i of eq makes field i equal to its match value
	task automatic set_tk(input logic [6:0] eq);
		@(posedge mclk);
		tk_hundredths <= eq[0] ? mv[0] : dv[0];
		tk_seconds <= eq[1] ? mv[1] : dv[1];
		tk_minutes <= eq[2] ? mv[2] : dv[2];
		tk_hours <= eq[3] ? mv[3] : dv[3];
		tk_weekday <= eq[4] ? mv[4][2:0] : dv[4][2:0];
		tk_date <= eq[5] ? mv[5] : dv[5];
		tk_month <= eq[6] ? mv[6] : dv[6];
	endtask

	// Flag lands one edge after the tick, the pin one edge later
	task automatic tick(input int n = 1);
		@(posedge mclk);
		tk_tick <= 1'b1;
		repeat (n) @(posedge mclk);
		tk_tick <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task automatic run_code(input int u, input int c);
		logic rsv;
		logic e1;
		logic [6:0] sel;
		logic [7:0] wk;
		logic [7:0] wa;
		rsv = (c == 6) || (c == 5 && u == 0);
		e1 = !rsv && !(c == 7 && u == 0);
		sel = (c == 7) ? 7'h3E : ((c == 6) ? 7'h7F : 7'h01 << ((c + 1) % 6));
		wk = {u[0], c[2:0], 1'b0, 3'h5};
		wa = u[0] ? 8'h16 : 8'h0F;
		set_tk(7'h00);
		i_rda_host_model.wr(wa, wk);
		@(posedge mclk);
		alarm0_enable <= (u == 0);
		alarm1_enable <= (u == 1);
		tick();
		set_tk(sel);
		repeat (3) @(posedge mclk);
		#1;
		out_chk(u[0], 1'b0);
		tick();
		out_chk(u[0], e1);
		rchk(wa, {wk[7:4], e1, wk[2:0]});
		set_tk(7'h7F);
		tick();
		out_chk(u[0], !rsv);
		rchk(wa, {wk[7:4], !rsv, wk[2:0]});
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		for (int a = 12; a < 25; a++) begin
			rchk(a[7:0], (a == 15 || a == 22) ? 8'h01 : 8'h00);
		end
		for (int i = 0; i < 5; i++) begin
			i_rda_host_model.wr(ta[i], td[i]);
			rchk(ta[i], te[i]);
		end
		for (int i = 0; i < 10; i++) begin
			i_rda_host_model.wr(ma[i], mv[mf[i]]);
		end
		for (int u = 0; u < 2; u++) begin
			for (int c = 0; c < 8; c++) begin
				run_code(u, c);
			end
		end
		rchk(8'h0E, 8'h51);
		rchk(8'h15, 8'h51);
		// A match still standing after the clear must not set the flag again
		i_rda_host_model.wr(8'h16, 8'hF5);
		tick();
		out_chk(1'b1, 1'b0);
		set_tk(7'h00);
		tick();
		set_tk(7'h7F);
		// Back-to-back updates on a standing match: only the first may set
		tick(2);
		set_tk(7'h00);
		tick();
		out_chk(1'b1, 1'b1);
		@(posedge mclk);
		alarm1_enable <= 1'b0;
		i_rda_host_model.wr(8'h16, 8'hF5);
		set_tk(7'h7F);
		tick();
		out_chk(1'b1, 1'b0);
		rchk(8'h16, 8'hF5);
		i_rda_host_model.wr(8'h0F, 8'h85);
		@(posedge mclk);
		alarm0_enable <= 1'b1;
		set_tk(7'h00);
		tick();
		set_tk(7'h7F);
		tick();
		out_chk(1'b1, 1'b1);
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		$display("[ERR] %0t watchdog expired", $time);
		give_verdict();
	end
endmodule
